// File: motor_ctrl_if.sv
// Register link and speed pin between host and motor controller
`timescale 1ns/1ps
interface motor_ctrl_if;
	logic        req;
	logic        we;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        ack;
	logic [15:0] rdata;
	logic        speed_pin;

	modport device(input req, we, addr, wdata, speed_pin, output ack, rdata);
	modport host(output req, we, addr, wdata, speed_pin, input ack, rdata);
endinterface

// File: motor_nvm_device.sv
// Motor controller end: overvoltage stop, low-power states, configuration memory
// Summary of operation
// - Overvoltage stops drive until supply falls back
// - Low-power state stops motor drive
// - Sleep: regulator, serial off, volatile registers reset
// - Standby: regulator, registers, serial stay alive
// - Analog: low level for entry time enters
// - Analog: above exit level leaves standby
// - Analog sleep exit needs digital high
// - Pulse mode: low enters, duty wakes sleep
// - Serial: zero enters, non-zero leaves standby
// - Only speed pin high ends sleep
// - Host sleep sequence one via speed register
// - Host sleep sequence two via motor disable
// - Seven sixteen-bit nonvolatile configuration words
// - Host waits, disables motor before access
// - Unlock needs zero then key writes
// - Ready flag reported, host polls it
// - Host fills all seven shadow words first
// - Write command copies shadows to memory
// - Read command loads shadows from memory
// - Host re-enables motor after transfer
// - Program stopped, power cycle, read back
// - Resistance, back-EMF codes in first words
// - Code decodes as mantissa shifted left
`timescale 1ns/1ps
module motor_nvm_device #(
	parameter bit SLEEP_VARIANT       = 1'b1,
	parameter int ENTRY_CYCLES        = motor_nvm_pkg::ENTRY_CYCLES,
	parameter int STANDBY_EXIT_CYCLES = motor_nvm_pkg::STANDBY_EXIT_CYCLES,
	parameter int EXIT_CYCLES         = motor_nvm_pkg::EXIT_CYCLES,
	parameter int GAP_CYCLES          = motor_nvm_pkg::GAP_CYCLES,
	parameter int NVM_WORD_CYCLES     = motor_nvm_pkg::NVM_WORD_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Host link
	motor_ctrl_if.device     link,
	// Comparators
	input  wire logic        ov_above_rise_i,
	input  wire logic        ov_below_fall_i,
	input  wire logic        speed_below_entry_i,
	input  wire logic        speed_above_exit_i,
	// Status and drive
	output logic             motor_drive_o,
	output logic             regulator_en_o,
	output logic             serial_en_o,
	output logic             lowpower_o,
	output logic [8:0]       speed_o,
	output logic [10:0]      phase_resistance_o,
	output logic [10:0]      backemf_o
);
	localparam int CW = motor_nvm_pkg::CNT_W;
	localparam int NW = motor_nvm_pkg::NVM_WORDS;
	if (ENTRY_CYCLES < 1 || STANDBY_EXIT_CYCLES < 1 || EXIT_CYCLES < 1 || GAP_CYCLES < 1 ||
		NVM_WORD_CYCLES < 1 || ENTRY_CYCLES >= 2**CW || STANDBY_EXIT_CYCLES >= 2**CW ||
		EXIT_CYCLES >= 2**CW || GAP_CYCLES >= 2**CW || NVM_WORD_CYCLES >= 2**CW) begin : g_check
		$error("Cycle counts must lie between 1 and the counter range");
	end
	typedef enum logic [1:0] {nv_idle, nv_write, nv_read} nvm_state_e;
	typedef enum logic {pw_active, pw_lowpower} power_state_e;
	// ==========================================================
	// State
	nvm_state_e    nv_state_reg;
	power_state_e  pw_state_reg;
	logic [15:0]   speed_cmd_reg, motor_ctrl_reg, control_reg, rdata_reg, rd_next;
	logic          armed_reg, unlocked_reg, ready_reg, ack_reg, ov_reg;
	logic [15:0]   shadow_reg [NW], nvm_mem [NW];
	logic [2:0]    idx_reg;
	logic [CW-1:0] wait_cnt_reg, entry_cnt_reg, exit_cnt_reg, gap_cnt_reg, exit_last;
	logic          asleep, take, wr, serial_mode, pwm_mode, speed_zero, enter_cond;
	logic          exit_cond, enter_now, leave_now, soft_clear, word_done, ctl_ok, nvm_start;
	function automatic logic shadow_hit(input logic [7:0] a);
		return a >= motor_nvm_pkg::SHADOW_FIRST_OFS && a <= motor_nvm_pkg::SHADOW_LAST_OFS;
	endfunction
	function automatic logic [2:0] shadow_index(input logic [7:0] a);
		return 3'(a - motor_nvm_pkg::SHADOW_FIRST_OFS);
	endfunction
	function automatic logic [10:0] decode_code(input logic [6:0] c);
		return {7'h00, c[3:0]} << c[6:4];
	endfunction
	// ==========================================================
	// Decode
	assign asleep      = SLEEP_VARIANT && pw_state_reg == pw_lowpower;
	assign take        = link.req && !ack_reg && !asleep;
	assign wr          = take && link.we;
	assign serial_mode = speed_cmd_reg[motor_nvm_pkg::SERIAL_SPEED_BIT];
	assign pwm_mode    = motor_ctrl_reg[motor_nvm_pkg::PWM_SELECT_BIT];
	assign speed_zero  = speed_cmd_reg[8:0] == 9'h000;
	// Entry source follows the speed mode
	assign enter_cond  = serial_mode ? speed_zero :
		pwm_mode ? !link.speed_pin :
		speed_below_entry_i;
	// Sleep loses the serial port, so only the pin can wake it
	assign exit_cond   = SLEEP_VARIANT ? link.speed_pin :
		serial_mode ? !speed_zero :
		pwm_mode ? link.speed_pin :
		speed_above_exit_i;
	assign exit_last   = (SLEEP_VARIANT || pwm_mode || serial_mode) ? CW'(EXIT_CYCLES - 1) :
		CW'(STANDBY_EXIT_CYCLES - 1);
	assign enter_now   = pw_state_reg == pw_active && nv_state_reg == nv_idle && enter_cond &&
		entry_cnt_reg == CW'(ENTRY_CYCLES - 1);
	assign leave_now   = pw_state_reg == pw_lowpower && exit_cond && exit_cnt_reg == exit_last;
	assign soft_clear  = rst_i || (SLEEP_VARIANT && enter_now);
	assign word_done   = nv_state_reg != nv_idle && wait_cnt_reg == CW'(NVM_WORD_CYCLES - 1);
	assign ctl_ok      = !link.wdata[motor_nvm_pkg::CTL_SHADOW_BIT] && !link.wdata[motor_nvm_pkg::CTL_REFRESH_BIT] &&
		link.wdata[motor_nvm_pkg::CTL_MODE_LSB+1:motor_nvm_pkg::CTL_MODE_LSB] == motor_nvm_pkg::MODE_MASS;
	assign nvm_start   = wr && link.addr == motor_nvm_pkg::CONTROL_OFS && unlocked_reg && nv_state_reg == nv_idle && ctl_ok;
	// ==========================================================
	// Register link
	always_comb begin
		rd_next = 16'h0000;
		if (link.addr == motor_nvm_pkg::SPEED_CMD_OFS) begin
			rd_next = speed_cmd_reg;
		end else if (link.addr == motor_nvm_pkg::STATUS_OFS) begin
			rd_next[motor_nvm_pkg::READY_BIT] = ready_reg;
		end else if (link.addr == motor_nvm_pkg::CONTROL_OFS) begin
			rd_next = control_reg;
		end else if (link.addr == motor_nvm_pkg::MOTOR_CTRL_OFS) begin
			rd_next = motor_ctrl_reg;
		end else if (shadow_hit(link.addr)) begin
			rd_next = shadow_reg[shadow_index(link.addr)];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 16'h0000;
		end else begin
			ack_reg <= take;
			if (take) begin
				rdata_reg <= rd_next;
			end
		end
	end
	assign link.ack   = ack_reg;
	assign link.rdata = rdata_reg;
	// Volatile registers are lost on sleep entry
	always_ff @(posedge clk_i) begin
		if (soft_clear) begin
			speed_cmd_reg  <= motor_nvm_pkg::SPEED_CMD_RST;
			motor_ctrl_reg <= motor_nvm_pkg::MOTOR_CTRL_RST;
			control_reg    <= motor_nvm_pkg::CONTROL_RST;
		end else if (wr) begin
			if (link.addr == motor_nvm_pkg::SPEED_CMD_OFS) begin
				speed_cmd_reg <= link.wdata;
			end else if (link.addr == motor_nvm_pkg::MOTOR_CTRL_OFS) begin
				motor_ctrl_reg <= link.wdata;
			end else if (link.addr == motor_nvm_pkg::CONTROL_OFS) begin
				control_reg <= link.wdata;
			end
		end
	end
	// Any write to the unlock register other than the expected step relocks
	always_ff @(posedge clk_i) begin
		if (soft_clear) begin
			armed_reg    <= 1'b0;
			unlocked_reg <= 1'b0;
		end else if (wr && link.addr == motor_nvm_pkg::UNLOCK_OFS) begin
			armed_reg    <= link.wdata == motor_nvm_pkg::KEY_CLEAR;
			unlocked_reg <= armed_reg && link.wdata == motor_nvm_pkg::KEY_OPEN;
		end
	end
	// ==========================================================
	// Configuration memory transfer
	always_ff @(posedge clk_i) begin
		if (soft_clear) begin
			nv_state_reg <= nv_read;
			idx_reg      <= 3'h0;
			wait_cnt_reg <= '0;
			ready_reg    <= 1'b0;
		end else if (nv_state_reg == nv_idle) begin
			if (nvm_start) begin
				nv_state_reg <= link.wdata[motor_nvm_pkg::CTL_WRITE_BIT] ? nv_write : nv_read;
				idx_reg      <= 3'h0;
				wait_cnt_reg <= '0;
				ready_reg    <= 1'b0;
			end
		end else if (word_done) begin
			wait_cnt_reg <= '0;
			idx_reg      <= idx_reg + 3'h1;
			if (idx_reg == 3'(NW - 1)) begin
				nv_state_reg <= nv_idle;
				ready_reg    <= 1'b1;
			end
		end else begin
			wait_cnt_reg <= wait_cnt_reg + CW'(1);
		end
	end
	always_ff @(posedge clk_i) begin
		if (word_done && nv_state_reg == nv_read) begin
			shadow_reg[idx_reg] <= nvm_mem[idx_reg];
		end else if (wr && shadow_hit(link.addr)) begin
			shadow_reg[shadow_index(link.addr)] <= link.wdata;
		end
	end
	// Not reset: contents survive everything but a write command
	always_ff @(posedge clk_i) begin
		if (word_done && nv_state_reg == nv_write) begin
			nvm_mem[idx_reg] <= shadow_reg[idx_reg];
		end
	end
	// ==========================================================
	// Low-power qualification
	always_ff @(posedge clk_i) begin
		if (rst_i || pw_state_reg != pw_active || !enter_cond || nv_state_reg != nv_idle) begin
			entry_cnt_reg <= '0;
		end else if (entry_cnt_reg != CW'(ENTRY_CYCLES - 1)) begin
			entry_cnt_reg <= entry_cnt_reg + CW'(1);
		end
	end
	// Highs accumulate across short lows so a narrow pulse train still wakes
	always_ff @(posedge clk_i) begin
		if (rst_i || pw_state_reg != pw_lowpower) begin
			exit_cnt_reg <= '0;
			gap_cnt_reg  <= '0;
		end else if (exit_cond) begin
			gap_cnt_reg <= '0;
			if (exit_cnt_reg != exit_last) begin
				exit_cnt_reg <= exit_cnt_reg + CW'(1);
			end
		end else if (gap_cnt_reg == CW'(GAP_CYCLES - 1)) begin
			exit_cnt_reg <= '0;
			gap_cnt_reg  <= '0;
		end else begin
			gap_cnt_reg <= gap_cnt_reg + CW'(1);
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pw_state_reg <= pw_active;
		end else if (enter_now) begin
			pw_state_reg <= pw_lowpower;
		end else if (leave_now) begin
			pw_state_reg <= pw_active;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ov_reg <= 1'b0;
		end else if (ov_above_rise_i) begin
			ov_reg <= 1'b1;
		end else if (ov_below_fall_i) begin
			ov_reg <= 1'b0;
		end
	end
	// ==========================================================
	// Outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			motor_drive_o      <= 1'b0;
			regulator_en_o     <= 1'b1;
			serial_en_o        <= 1'b1;
			lowpower_o         <= 1'b0;
			speed_o            <= 9'h000;
			phase_resistance_o <= 11'h000;
			backemf_o          <= 11'h000;
		end else begin
			motor_drive_o      <= !ov_reg && pw_state_reg == pw_active &&
				!motor_ctrl_reg[motor_nvm_pkg::MOTOR_DISABLE_BIT];
			regulator_en_o     <= !asleep;
			serial_en_o        <= !asleep;
			lowpower_o         <= pw_state_reg == pw_lowpower;
			speed_o            <= speed_cmd_reg[8:0];
			phase_resistance_o <= decode_code(shadow_reg[0][6:0]);
			backemf_o          <= decode_code(shadow_reg[1][6:0]);
		end
	end
endmodule

// File: motor_nvm_host.sv
// Host end: Wishbone command registers driving the register link and speed pin
`timescale 1ns/1ps
module motor_nvm_host #(
	parameter int TIMEOUT_CYCLES = motor_nvm_pkg::HOST_TIMEOUT_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Device link
	motor_ctrl_if.host       link
);
	if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= 2**16) begin : g_check
		$error("Timeout must lie between 1 and 65535");
	end

	// ==========================================================
	// State
	logic        req_reg;
	logic        we_reg;
	logic [7:0]  addr_reg;
	logic [15:0] wdata_reg;
	logic [15:0] rdata_reg;
	logic        pin_reg;
	logic        timeout_reg;
	logic [15:0] wait_reg;
	logic        bus_take;
	logic        bus_wr;
	logic [31:0] rd_next;

	assign bus_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr   = bus_take && wb_we_i;

	// ==========================================================
	// Wishbone registers
	always_comb begin
		rd_next = 32'h0000_0000;
		if (wb_adr_i == motor_nvm_pkg::HOST_DATA_OFS) begin
			rd_next = {16'h0000, wdata_reg};
		end else if (wb_adr_i == motor_nvm_pkg::HOST_CMD_OFS) begin
			rd_next = {23'h000000, we_reg, addr_reg};
		end else if (wb_adr_i == motor_nvm_pkg::HOST_STATUS_OFS) begin
			rd_next = {rdata_reg, 14'h0000, timeout_reg, req_reg};
		end else if (wb_adr_i == motor_nvm_pkg::HOST_PIN_OFS) begin
			rd_next = {31'h00000000, pin_reg};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_take;
			if (bus_take) begin
				wb_dat_o <= rd_next;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdata_reg <= 16'h0000;
			pin_reg   <= 1'b0;
		end else if (bus_wr) begin
			if (wb_adr_i == motor_nvm_pkg::HOST_DATA_OFS) begin
				if (wb_sel_i[0]) begin
					wdata_reg[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					wdata_reg[15:8] <= wb_dat_i[15:8];
				end
			end else if (wb_adr_i == motor_nvm_pkg::HOST_PIN_OFS && wb_sel_i[0]) begin
				pin_reg <= wb_dat_i[0];
			end
		end
	end

	// ==========================================================
	// Link transaction: held until the device answers or time runs out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_reg     <= 1'b0;
			we_reg      <= 1'b0;
			addr_reg    <= 8'h00;
			rdata_reg   <= 16'h0000;
			timeout_reg <= 1'b0;
			wait_reg    <= 16'h0000;
		end else if (req_reg) begin
			if (link.ack) begin
				req_reg   <= 1'b0;
				rdata_reg <= link.rdata;
			end else if (wait_reg == 16'(TIMEOUT_CYCLES - 1)) begin
				req_reg     <= 1'b0;
				timeout_reg <= 1'b1;
			end else begin
				wait_reg <= wait_reg + 16'h0001;
			end
		end else if (bus_wr && wb_adr_i == motor_nvm_pkg::HOST_CMD_OFS && wb_sel_i[0] && wb_sel_i[1]) begin
			req_reg     <= 1'b1;
			we_reg      <= wb_dat_i[motor_nvm_pkg::HOST_CMD_WE_BIT];
			addr_reg    <= wb_dat_i[7:0];
			timeout_reg <= 1'b0;
			wait_reg    <= 16'h0000;
		end
	end

	assign link.req       = req_reg;
	assign link.we        = we_reg;
	assign link.addr      = addr_reg;
	assign link.wdata     = wdata_reg;
	assign link.speed_pin = pin_reg;
endmodule

// File: motor_nvm_monitor.sv
// Protocol and register checker for the host-to-device link
`timescale 1ns/1ps
module motor_nvm_monitor (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// Link
	input wire logic        req,
	input wire logic        we,
	input wire logic [7:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        ack,
	input wire logic [15:0] rdata,
	input wire logic        speed_pin
);
	// ==========================================================
	// Helpers
	logic [15:0] spd_reg;
	logic [7:0]  stall_reg;
	logic        mapped;
	assign mapped = (addr inside {8'h30, 8'h31, 8'h32, 8'h35, 8'h60}) || (addr >= 8'h90 && addr <= 8'h96);
	// Long unanswered request means sleep, and sleep clears the speed word
	always_ff @(posedge clk_i) begin
		if (rst_i || !req || ack) begin
			stall_reg <= 8'h00;
		end else if (stall_reg != 8'hff) begin
			stall_reg <= stall_reg + 8'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || stall_reg == 8'h03) begin
			spd_reg <= 16'h0000;
		end else if (ack && we && addr == 8'h30) begin
			spd_reg <= wdata;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// Assertions
	a_ack_one_cycle: assert property (ack |=> !ack)
		else $error("ack held for more than one cycle");
	a_ack_exact_delay: assert property (ack |-> $past(req) && !$past(req, 2))
		else $error("ack not one cycle after request");
	a_req_held: assert property (req && $past(req) |-> $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed while pending");
	a_req_release: assert property (ack |=> !req)
		else $error("request not dropped after ack");
	a_key_hidden: assert property (ack && !we && addr == 8'h31 |-> rdata == 16'h0000)
		else $error("unlock key readable");
	a_unmapped_zero: assert property (ack && !we && !mapped |-> rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_rdata_held: assert property ($changed(rdata) |-> ack)
		else $error("read data changed without ack");
	a_speed_readback: assert property (ack && !we && addr == 8'h30 |->
		{rdata[15], rdata[8:0]} == {spd_reg[15], spd_reg[8:0]})
		else $error("speed word readback wrong");
	c_ctrl_write: cover property (ack && we && addr == 8'h35);
	c_sleep_stall: cover property (stall_reg == 8'h03);
	c_pin_rise: cover property ($rose(speed_pin));
endmodule

// File: motor_nvm_pkg.sv
// Shared constants for the low-power and nonvolatile configuration controller
package motor_nvm_pkg;
	// ==========================================================
	// Widths
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 16;
	localparam int NVM_WORDS  = 7;
	localparam int NVM_BITS   = NVM_WORDS * DATA_W;
	localparam int SPEED_W    = 9;
	localparam int CODE_W     = 7;
	localparam int DECODED_W  = 11;
	localparam int CNT_W      = 24;

	// ==========================================================
	// Device register offsets
	localparam logic [7:0] SPEED_CMD_OFS    = 8'h30;
	localparam logic [7:0] UNLOCK_OFS       = 8'h31;
	localparam logic [7:0] STATUS_OFS       = 8'h32;
	localparam logic [7:0] CONTROL_OFS      = 8'h35;
	localparam logic [7:0] MOTOR_CTRL_OFS   = 8'h60;
	localparam logic [7:0] SHADOW_FIRST_OFS = 8'h90;
	localparam logic [7:0] SHADOW_LAST_OFS  = 8'h96;

	// ==========================================================
	// Field positions and codes
	localparam int SERIAL_SPEED_BIT   = 15;
	localparam int MOTOR_DISABLE_BIT  = 15;
	localparam int PWM_SELECT_BIT     = 0;
	localparam int READY_BIT          = 0;
	localparam int CTL_MODE_LSB       = 0;
	localparam int CTL_WRITE_BIT      = 2;
	localparam int CTL_REFRESH_BIT    = 3;
	localparam int CTL_SHADOW_BIT     = 4;
	localparam logic [1:0] MODE_MASS  = 2'h2;
	localparam logic [15:0] KEY_CLEAR = 16'h0000;
	localparam logic [15:0] KEY_OPEN  = 16'hc0de;

	// ==========================================================
	// Reset values
	localparam logic [15:0] SPEED_CMD_RST  = 16'h0000;
	localparam logic [15:0] MOTOR_CTRL_RST = 16'h0000;
	localparam logic [15:0] CONTROL_RST    = 16'h0000;

	// ==========================================================
	// Timing
	localparam int CLK_HZ              = 20_000_000;
	localparam int CLK_MHZ             = CLK_HZ / 1_000_000;
	localparam int ENTRY_TIME_US       = 1000;
	localparam int STANDBY_EXIT_TIME_US = 100;
	localparam int EXIT_TIME_US        = 200;
	localparam int GAP_TIME_US         = 10000;
	localparam int NVM_WORD_TIME_US    = 10;
	localparam int ENTRY_CYCLES        = ENTRY_TIME_US * CLK_MHZ;
	localparam int STANDBY_EXIT_CYCLES = STANDBY_EXIT_TIME_US * CLK_MHZ;
	localparam int EXIT_CYCLES         = EXIT_TIME_US * CLK_MHZ;
	localparam int GAP_CYCLES          = GAP_TIME_US * CLK_MHZ;
	localparam int NVM_WORD_CYCLES     = NVM_WORD_TIME_US * CLK_MHZ;
	localparam int HOST_TIMEOUT_CYCLES = 1000;

	// ==========================================================
	// Host command registers
	localparam logic [7:0] HOST_DATA_OFS   = 8'h00;
	localparam logic [7:0] HOST_CMD_OFS    = 8'h04;
	localparam logic [7:0] HOST_STATUS_OFS = 8'h08;
	localparam logic [7:0] HOST_PIN_OFS    = 8'h0c;
	localparam int HOST_CMD_WE_BIT         = 8;
endpackage

// File: tb.sv
// Self-checking bench joining host and device ends over the register link
`timescale 1ns/1ps
module tb;
	// ==========================================================
	// Signals
	logic        clk_i, rst_i, cyc, stb, wwe, wb_ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, wb_dat, wbq;
	logic        ov_r, ov_f, below, above, drive, reg_en, ser_en, lp;
	logic [8:0]  spd;
	logic [10:0] res, bemf;
	logic [15:0] q;
	int          miscompares, cmp_count;
	int          sh[7], nv[7];
	motor_ctrl_if i_motor_ctrl_if();
	motor_nvm_host #(.TIMEOUT_CYCLES(50)) i_motor_nvm_host (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_sel_i(sel), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .link(i_motor_ctrl_if));
	motor_nvm_device #(.ENTRY_CYCLES(20), .EXIT_CYCLES(10), .GAP_CYCLES(8),
		.NVM_WORD_CYCLES(2)) i_motor_nvm_device (.clk_i(clk_i), .rst_i(rst_i), .link(i_motor_ctrl_if),
		.ov_above_rise_i(ov_r), .ov_below_fall_i(ov_f), .speed_below_entry_i(below),
		.speed_above_exit_i(above), .motor_drive_o(drive), .regulator_en_o(reg_en), .serial_en_o(ser_en),
		.lowpower_o(lp), .speed_o(spd), .phase_resistance_o(res), .backemf_o(bemf));
	motor_nvm_monitor i_motor_nvm_monitor (.clk_i(clk_i), .rst_i(rst_i), .req(i_motor_ctrl_if.req),
		.we(i_motor_ctrl_if.we), .addr(i_motor_ctrl_if.addr), .wdata(i_motor_ctrl_if.wdata),
		.ack(i_motor_ctrl_if.ack), .rdata(i_motor_ctrl_if.rdata), .speed_pin(i_motor_ctrl_if.speed_pin));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// ==========================================================
	// Tasks
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic hang();
		miscompares++;
		final_report();
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", s, e, g);
			miscompares++;
		end
	endtask
	// Classic single cycle; the slave's latency is never assumed
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		wwe <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		if (n >= 50) hang();
		wbq = wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic lk(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		if (w) wb(1'b1, 8'h00, {16'h0000, d});
		wb(1'b1, 8'h04, {23'h000000, w, a});
		do begin
			wb(1'b0, 8'h08, 32'h00000000);
			n++;
		end while (wbq[0] !== 1'b0 && n < 100);
		if (n >= 100) hang();
		q = wbq[31:16];
	endtask
	task automatic wrdy();
		int n;
		n = 0;
		do begin
			lk(1'b0, 8'h32, 16'h0000);
			n++;
		end while (q[0] !== 1'b1 && n < 40);
		if (n >= 40) hang();
	endtask
	task automatic wlp(input logic v);
		int n;
		n = 0;
		while (lp !== v && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		chk("lowpower", {31'h0, v}, {31'h0, lp});
	endtask
	task automatic unl();
		lk(1'b1, 8'h31, 16'h0000);
		lk(1'b1, 8'h31, 16'hc0de);
	endtask
	task automatic fill();
		for (int i = 0; i < 7; i++) begin
			sh[i] = $urandom & 16'hffff;
			lk(1'b1, 8'h90 + i[7:0], sh[i][15:0]);
		end
	endtask
	function automatic int dec(input int c);
		return (c & 15) << ((c >> 4) & 7);
	endfunction
	// ==========================================================
	// Main sequence
	initial begin
		{cyc, stb, wwe, adr, dat, ov_r, below} = '0;
		{ov_f, above, rst_i} = 3'b111;
		sel = 4'hf;
		miscompares = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		void'($urandom(2099));
		wrdy();
		lk(1'b1, 8'h60, 16'h8000);
		chk("drive", 0, drive);
		unl();
		fill();
		lk(1'b1, 8'h35, 16'h0006);
		nv = sh;
		wrdy();
		fill();
		// Wrong key must leave the memory locked
		lk(1'b1, 8'h31, 16'h0000);
		lk(1'b1, 8'h31, 16'h1234);
		lk(1'b1, 8'h35, 16'h0006);
		wrdy();
		unl();
		lk(1'b1, 8'h35, 16'h0002);
		sh = nv;
		wrdy();
		for (int i = 0; i < 8; i++) begin
			lk(1'b0, 8'h90 + i[7:0], 16'h0000);
			chk("shadow", i < 7 ? sh[i] : 0, q);
		end
		chk("resistance", dec(sh[0]), res);
		chk("backemf", dec(sh[1]), bemf);
		lk(1'b0, 8'h31, 16'h0000);
		chk("key", 0, q);
		lk(1'b1, 8'h60, 16'h0000);
		chk("drive", 1, drive);
		sel <= 4'h1;
		wb(1'b1, 8'h00, 32'h0000abcd);
		sel <= 4'hf;
		wb(1'b0, 8'h00, 32'h00000000);
		chk("host data", 32'h000000cd, wbq);
		$display("memory test done");
		ov_r <= 1'b1;
		ov_f <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("drive", 0, drive);
		ov_r <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("drive", 0, drive);
		ov_f <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("drive", 1, drive);
		$display("overvoltage test done");
		lk(1'b1, 8'h30, 16'h0064);
		below <= 1'b1;
		wlp(1'b1);
		below <= 1'b0;
		chk("drive", 0, drive);
		chk("power", 2'b00, {reg_en, ser_en});
		lk(1'b0, 8'h30, 16'h0000);
		chk("timeout", 1, wbq[1]);
		chk("asleep", 1, lp);
		wb(1'b1, 8'h0c, 32'h00000001);
		wlp(1'b0);
		chk("power", 2'b11, {reg_en, ser_en});
		wrdy();
		lk(1'b0, 8'h30, 16'h0000);
		chk("speed_cmd", 0, q);
		lk(1'b0, 8'h90, 16'h0000);
		chk("shadow", nv[0], q);
		wb(1'b1, 8'h0c, 32'h00000000);
		$display("analog test done");
		lk(1'b1, 8'h60, 16'h0001);
		wlp(1'b1);
		// Short lows stay under the gap, so the highs add up
		for (int i = 0; i < 5; i++) begin
			wb(1'b1, 8'h0c, 32'h00000001);
			wb(1'b1, 8'h0c, 32'h00000000);
		end
		wlp(1'b0);
		$display("pulse test done");
		lk(1'b1, 8'h60, 16'h8000);
		chk("drive", 0, drive);
		lk(1'b1, 8'h30, 16'h8064);
		chk("speed", 100, spd);
		lk(1'b1, 8'h60, 16'h0000);
		lk(1'b1, 8'h30, 16'h8000);
		wlp(1'b1);
		wb(1'b1, 8'h0c, 32'h00000001);
		wlp(1'b0);
		$display("serial test done");
		final_report();
	end
endmodule
